// ---- test/fan_far_side.sv ----
// Far-side model: fan tachometer and remote diode front end.
`timescale 1ns/100ps
`default_nettype none

module fan_far_side (
  input  wire logic        clk,
  input  wire logic [15:0] fan_pulse_count_period,
  input  wire logic [2:0]  gain_pick,
  input  wire logic        over_crit,
  output logic             fan_fan_pulse_count_in,
  output logic [2:0]       detected_gain_code,
  output logic             crit_temp_limit
);
  logic [15:0] phase_r = 16'h0000;

  // A period of zero is a stalled rotor: the pin rests low, no edges.
  always_ff @(posedge clk) begin
    if (fan_pulse_count_period == 16'h0000 || phase_r >= fan_pulse_count_period - 16'h0001) begin
      phase_r <= 16'h0000;
    end else begin
      phase_r <= phase_r + 16'h0001;
    end
  end

  // Diode front end simply reports what the bench chose.
  assign fan_fan_pulse_count_in        = (fan_pulse_count_period != 16'h0000) && (phase_r < (fan_pulse_count_period >> 1));
  assign detected_gain_code = gain_pick;
  assign crit_temp_limit    = over_crit;
endmodule : fan_far_side

`default_nettype wire

// ---- test/fan_regs_props.sv ----
// Port checker for the fan register bank.
`timescale 1ns/100ps
`default_nettype none

module fan_regs_props (
  input wire logic                     clk,
  input wire logic                     resetn,
  input wire logic                     scl_in,
  input wire logic                     sda_oe,
  input wire logic                     conv_start,
  input wire logic [2:0]               detected_gain_code,
  input wire logic                     crit_temp_limit,
  input wire fan_regs_pkg::comp_type   comp_active,
  input wire logic [5:0]               diode_ideality_trim_code,
  input wire logic [13:0]              ideality_factor_e4,
  input wire fan_regs_pkg::status_type status_flags,
  input wire logic                     alert_n
);
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // The flag follows the level whatever the masks say.
  a_crit_flag_set: assert property (crit_temp_limit |=> status_flags.crit_temp_limit)
    else $error("crit flag not set");
  a_crit_flag_clr: assert property (!crit_temp_limit |=> !status_flags.crit_temp_limit)
    else $error("crit flag not cleared");
  a_alert_has_cause: assert property (!alert_n |-> $past(status_flags) != '0)
    else $error("alert low without flag");
  a_alert_released: assert property (status_flags == '0 |=> alert_n)
    else $error("alert held without flag");
  a_comp_holds: assert property (!conv_start |=> $stable(comp_active))
    else $error("compensation moved between conversions");
  a_comp_auto_pick: assert property (conv_start ##1 comp_active.auto_mode |->
    comp_active.setting == $past(detected_gain_code))
    else $error("autodetect result not used");
  a_trim_nominal: assert property ((diode_ideality_trim_code == 6'h12) [*3] |->
    ideality_factor_e4 == 14'h2760)
    else $error("nominal factor wrong");
  a_trim_low_end: assert property ((diode_ideality_trim_code == 6'h08) [*3] |->
    ideality_factor_e4 < 14'h2760)
    else $error("low trim not below nominal");
  // Data may only move while the bus clock is low, or a start is faked.
  a_sda_low_phase: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data moved with clock high");

  c_alert: cover property (!alert_n);
  c_fan_slow: cover property (status_flags.fan_slow);
  c_manual: cover property (conv_start ##1 !comp_active.auto_mode);
endmodule : fan_regs_props

`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the fan register bank.
`timescale 1ns/100ps
`default_nettype none

module tb;
  localparam int         H     = 8;
  localparam logic [6:0] SLAVE = 7'h2a;
  logic        clk, resetn, scl, sda_drv, conv_start, over_crit, ack;
  logic [1:0]  action;
  logic [2:0]  gain_pick;
  logic [7:0]  rdat;
  logic [13:0] prev;
  logic [15:0] fan_pulse_count_period;
  int          miscompares = 0;
  int          cmp_count = 0;
  wire         sda_out, sda_oe, fan_pulse_count, crit, alert_n;
  wire [2:0]   det_gain;
  wire [5:0]   trim;
  wire [13:0]  factor;
  wire fan_regs_pkg::comp_type   comp;
  wire fan_regs_pkg::status_type flags;
  // Open drain with pull-up: low if either side pulls.
  wire         sda = (sda_oe ? sda_out : 1'b1) & sda_drv;

  fan_fan_pulse_count_and_diode_trim_regs #(.SLAVE_ADDR(SLAVE)) i_dut (
    .clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .fan_fan_pulse_count_in(fan_pulse_count), .conv_start(conv_start),
    .detected_gain_code(det_gain), .crit_temp_limit(crit), .count_limit_action(action),
    .comp_active(comp), .diode_ideality_trim_code(trim), .ideality_factor_e4(factor),
    .status_flags(flags), .alert_n(alert_n));
  fan_far_side i_far (.clk(clk), .fan_pulse_count_period(fan_pulse_count_period), .gain_pick(gain_pick),
    .over_crit(over_crit), .fan_fan_pulse_count_in(fan_pulse_count), .detected_gain_code(det_gain),
    .crit_temp_limit(crit));

  // ---------------------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Data moves one cycle after the clock falls, never alongside it.
  task automatic clk_bit(input logic b, output logic s);
    tick(1);
    sda_drv = b;
    tick(H);
    scl = 1'b1;
    tick(H / 2);
    s = sda;
    tick(H / 2);
    scl = 1'b0;
  endtask : clk_bit
  task automatic start;
    tick(1);
    sda_drv = 1'b1;
    tick(H);
    scl = 1'b1;
    tick(H);
    sda_drv = 1'b0;
    tick(H);
    scl = 1'b0;
  endtask : start
  task automatic stop;
    tick(1);
    sda_drv = 1'b0;
    tick(H);
    scl = 1'b1;
    tick(H);
    sda_drv = 1'b1;
    tick(H);
  endtask : stop
  task automatic tx(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, ack);
  endtask : tx
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    tx({SLAVE, 1'b0});
    tx(a);
    tx(d);
    stop();
    chk({15'h0000, ack}, 16'h0000);
    tick(4);
  endtask : wr
  // Read ends with a not-acknowledge so the device lets go of the line.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    start();
    tx({SLAVE, 1'b0});
    tx(a);
    start();
    tx({SLAVE, 1'b1});
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, rdat[i]);
    clk_bit(1'b1, ack);
    stop();
    chk({8'h00, rdat}, {8'h00, e});
  endtask : rd
  task automatic pulse;
    conv_start = 1'b1;
    tick(1);
    conv_start = 1'b0;
    tick(2);
  endtask : pulse
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------------------
  // Clock, watchdog and tests
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    summarize();
  end
  initial begin
    {resetn, conv_start, over_crit, action, gain_pick, fan_pulse_count_period} = '0;
    {scl, sda_drv} = 2'b11;
    tick(10);
    resetn = 1'b1;
    tick(3);
    rd(8'h16, 8'ha4);
    rd(8'h17, 8'h12);
    rd(8'h18, 8'h08);
    rd(8'h46, 8'hff);
    rd(8'h47, 8'hff);
    rd(8'h48, 8'hff);
    rd(8'h49, 8'hff);
    chk({12'h000, comp}, 16'h000f);
    chk({2'h0, factor}, 16'h2760);
    rd(8'h30, 8'h00);
    // A foreign address must not be acknowledged.
    start();
    tx({7'h2b, 1'b0});
    stop();
    chk({15'h0000, ack}, 16'h0001);
    wr(8'h46, 8'h00);
    rd(8'h46, 8'hff);
    // Trim codes across the table rise in factor.
    prev = 14'h0000;
    for (int c = 8; c <= 55; c += 5) begin
      wr(8'h17, 8'(c));
      tick(3);
      chk({10'h000, trim}, 16'(c));
      chk({15'h0000, factor > prev}, 16'h0001);
      prev = factor;
    end
    wr(8'h17, 8'h37);
    tick(3);
    chk({2'h0, factor}, 16'h2946);
    wr(8'h17, 8'h08);
    tick(3);
    chk({2'h0, factor}, 16'h26dd);
    wr(8'h18, 8'hff);
    rd(8'h18, 8'h0f);
    for (int c = 0; c < 8; c++) begin
      wr(8'h18, 8'(c));
      pulse();
      chk({12'h000, comp}, 16'(c));
    end
    gain_pick = 3'h5;
    wr(8'h18, 8'h0b);
    pulse();
    chk({12'h000, comp}, 16'h000d);
    fan_pulse_count_period = 16'h15b3;
    tick(4 * 5555);
    rd(8'h46, 8'h05);
    rd(8'h47, 8'h00);
    wr(8'h48, 8'h04);
    wr(8'h49, 8'h00);
    tick(3);
    chk({15'h0000, flags.fan_slow}, 16'h0001);
    chk({15'h0000, alert_n}, 16'h0000);
    wr(8'h16, 8'ha5);
    chk({15'h0000, alert_n}, 16'h0001);
    chk({15'h0000, flags.fan_slow}, 16'h0001);
    action = 2'h1;
    tick(3);
    rd(8'h46, 8'hff);
    rd(8'h47, 8'hff);
    action = 2'h0;
    wr(8'h48, 8'hff);
    wr(8'h49, 8'hff);
    wr(8'h16, 8'ha4);
    chk({15'h0000, alert_n}, 16'h0001);
    over_crit = 1'b1;
    tick(3);
    chk({14'h0000, flags}, 16'h0002);
    chk({15'h0000, alert_n}, 16'h0000);
    wr(8'h16, 8'ha6);
    chk({15'h0000, alert_n}, 16'h0001);
    chk({14'h0000, flags}, 16'h0002);
    summarize();
  end
endmodule : tb

bind fan_fan_pulse_count_and_diode_trim_regs fan_regs_props i_props (
  .clk(clk), .resetn(resetn), .scl_in(scl_in), .sda_oe(sda_oe), .conv_start(conv_start),
  .detected_gain_code(detected_gain_code), .crit_temp_limit(crit_temp_limit),
  .comp_active(comp_active), .diode_ideality_trim_code(diode_ideality_trim_code),
  .ideality_factor_e4(ideality_factor_e4), .status_flags(status_flags), .alert_n(alert_n));

`default_nettype wire

// ---- verilog/fan_fan_pulse_count_and_diode_trim_regs.sv ----
// Fan count, limit, ideality trim and gain compensation registers behind a two-wire slave.
`include "fan_regs_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module fan_fan_pulse_count_and_diode_trim_regs #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a  // Arbitrary bus address.
) (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe,
  input  wire logic                    fan_fan_pulse_count_in,
  input  wire logic                    conv_start,
  input  wire logic [2:0]              detected_gain_code,
  input  wire logic                    crit_temp_limit,
  input  wire logic [1:0]              count_limit_action,
  output fan_regs_pkg::comp_type       comp_active,
  output logic [5:0]                   diode_ideality_trim_code,
  output logic [13:0]                  ideality_factor_e4,
  output fan_regs_pkg::status_type     status_flags,
  output logic                         alert_n
);

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  // Factor times ten thousand: 13 counts a step up from code 08h, plus the
  // small extra steps along the scale, so every listed code comes out exactly.
  function automatic logic [13:0] trim_factor(input logic [5:0] code);
    logic [13:0] f;
    logic [13:0] k;
    k = 14'(code) - 14'h0008;
    f = 14'h26dd + 14'h000d * k + 14'(k >= 14'h000a) + 14'(k >= 14'h000e) + 14'(k >= 14'h0013)
        + 14'(k >= 14'h0013) - 14'(k == 14'h0014) + 14'(k >= 14'h0017) + 14'(k >= 14'h0018);
    if (code < 6'h08) begin
      f = 14'd9949;
    end else if (code > 6'h37) begin
      f = 14'd10566;
    end
    trim_factor = f;
  endfunction : trim_factor

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic       scl_m_r, scl_s_r, scl_d_r;
  logic       sda_m_r, sda_s_r, sda_d_r;
  logic       count_limit_action_r, fan_pulse_count_s_r, fan_pulse_count_d_r;

  // Each pin passes two flops; edge detection compares the second with a third, delayed flop.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      {scl_m_r, scl_s_r, scl_d_r}    <= 3'h7;
      {sda_m_r, sda_s_r, sda_d_r}    <= 3'h7;
      {count_limit_action_r, fan_pulse_count_s_r, fan_pulse_count_d_r} <= 3'h0;
    end else begin
      {scl_m_r, scl_s_r, scl_d_r}    <= {scl_in, scl_m_r, scl_s_r};
      {sda_m_r, sda_s_r, sda_d_r}    <= {sda_in, sda_m_r, sda_s_r};
      {count_limit_action_r, fan_pulse_count_s_r, fan_pulse_count_d_r} <= {fan_fan_pulse_count_in, count_limit_action_r, fan_pulse_count_s_r};
    end
  end

  wire scl_rise  = scl_s_r & ~scl_d_r;
  wire scl_fall  = ~scl_s_r & scl_d_r;
  wire bus_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  wire bus_stop  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
  wire fan_pulse_count_rise = fan_pulse_count_s_r & ~fan_pulse_count_d_r;

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  logic [7:0]  alert_mask_r;
  logic [5:0]  trim_r;
  logic [3:0]  gain_comp_r;
  logic [15:0] limit_r;
  logic [15:0] measured_r;
  logic [15:0] run_r;
  logic [10:0] tick_r;
  logic [7:0]  high_shadow_r;
  logic        wr_r;
  logic [7:0]  wr_data_r;
  logic [7:0]  ptr_r;
  logic [7:0]  rd_data;

  // --------------------------------------------------------------------------
  // Fan count measurement
  // --------------------------------------------------------------------------
  wire tick      = (tick_r == 11'(`TICK_CYCLES - 1));
  wire run_full  = (run_r == `RST_COUNT_ONES);

  // period counting
  // Reference ticks between fan_pulse_count edges; a stalled fan saturates at all ones.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tick_r     <= 11'h000;
      run_r      <= 16'h0000;
      measured_r <= `RST_COUNT_ONES;
    end else begin
      tick_r <= tick ? 11'h000 : tick_r + 11'h001;
      if (fan_pulse_count_rise) begin
        measured_r <= run_r;
        run_r      <= {15'h0000, tick};  // A tick on the edge itself opens the new period.
      end else if (tick && !run_full) begin
        run_r <= run_r + 16'h0001;
      end else if (run_full) begin
        measured_r <= `RST_COUNT_ONES;
      end
    end
  end

  wire fan_slow = (measured_r > limit_r);

  wire [15:0] count_view = (fan_slow && count_limit_action != `LIMIT_ACTION_NONE)
                           ? `RST_COUNT_ONES : measured_r;

  // --------------------------------------------------------------------------
  // Status flags and alert
  // --------------------------------------------------------------------------
  // flags follow conditions
  // Flags track their limit conditions every cycle, masks or not.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_flags <= '0;
    end else begin
      status_flags.fan_slow        <= fan_slow;
      status_flags.crit_temp_limit <= crit_temp_limit;
    end
  end

  wire crit_irq = status_flags.crit_temp_limit & ~alert_mask_r[`BIT_CRIT_MASK];
  wire fan_irq  = status_flags.fan_slow & ~alert_mask_r[`BIT_FAN_MASK];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      alert_n <= 1'b1;
    end else begin
      alert_n <= ~(crit_irq | fan_irq);
    end
  end

  // --------------------------------------------------------------------------
  // Diode trim and gain compensation
  // --------------------------------------------------------------------------
  // autodetect at start
  // manual selection
  // The setting only changes at a conversion start, so one conversion
  // never sees two compensation values.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      comp_active <= '{auto_mode: 1'b1, setting: `COMP_OFF_CODE};
    end else if (conv_start) begin
      comp_active.auto_mode <= gain_comp_r[`BIT_COMP_AUTO];
      comp_active.setting   <= gain_comp_r[`BIT_COMP_AUTO] ? detected_gain_code
                                                           : gain_comp_r[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      diode_ideality_trim_code <= `RST_IDEALITY_TRIM;
      ideality_factor_e4       <= trim_factor(`RST_IDEALITY_TRIM);
    end else begin
      diode_ideality_trim_code <= trim_r;
      ideality_factor_e4       <= trim_factor(trim_r);
    end
  end

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  // writable limit
  always_ff @(posedge clk) begin
    if (!resetn) begin
      alert_mask_r <= `RST_ALERT_MASK;
      trim_r       <= `RST_IDEALITY_TRIM;
      gain_comp_r  <= `RST_GAIN_COMP;
      limit_r      <= {`RST_BYTE_ONES, `RST_BYTE_ONES};
    end else if (wr_r) begin
      if (ptr_r == `OFS_ALERT_MASK) begin
        alert_mask_r <= wr_data_r;
      end else if (ptr_r == `OFS_IDEALITY_TRIM) begin
        trim_r <= wr_data_r[5:0];
      end else if (ptr_r == `OFS_GAIN_COMP) begin
        gain_comp_r <= wr_data_r[3:0];
      end else if (ptr_r == `OFS_FAN_LIMIT_LOW) begin
        limit_r[7:0] <= wr_data_r;
      end else if (ptr_r == `OFS_FAN_LIMIT_HIGH) begin
        limit_r[15:8] <= wr_data_r;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read decode
  // --------------------------------------------------------------------------
  // upper bits zero
  // count readable
  // The high count byte reads from a copy taken with the low byte, so a
  // low-then-high read pair is never torn by a count update.
  always_comb begin
    if (ptr_r == `OFS_ALERT_MASK) begin
      rd_data = alert_mask_r;
    end else if (ptr_r == `OFS_IDEALITY_TRIM) begin
      rd_data = {2'h0, trim_r};
    end else if (ptr_r == `OFS_GAIN_COMP) begin
      rd_data = {4'h0, gain_comp_r};
    end else if (ptr_r == `OFS_FAN_COUNT_LOW) begin
      rd_data = count_view[7:0];
    end else if (ptr_r == `OFS_FAN_COUNT_HIGH) begin
      rd_data = high_shadow_r;
    end else if (ptr_r == `OFS_FAN_LIMIT_LOW) begin
      rd_data = limit_r[7:0];
    end else if (ptr_r == `OFS_FAN_LIMIT_HIGH) begin
      rd_data = limit_r[15:8];
    end else begin
      rd_data = 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // Two-wire slave
  // --------------------------------------------------------------------------
  fan_regs_pkg::smb_state_type state_r, after_r;
  logic [7:0] shift_r;
  logic [2:0] cnt_r;
  logic       got_r;

  wire ack_fall  = (state_r == fan_regs_pkg::ST_ACK) && scl_fall;
  wire rd_load   = ack_fall && (after_r == fan_regs_pkg::ST_RDATA);
  wire low_load  = rd_load && (ptr_r == `OFS_FAN_COUNT_LOW);
  wire addr_hit  = (shift_r[7:1] == SLAVE_ADDR);

  assign sda_out = 1'b0;

  // High byte copy, taken only when the low byte is read; a lone high byte
  // read therefore returns the copy of the last low byte read.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      high_shadow_r <= `RST_BYTE_ONES;
    end else if (low_load) begin
      high_shadow_r <= count_view[15:8];
    end
  end

  // Bytes are sampled on SCL rising edges; SDA changes after falling edges.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r   <= fan_regs_pkg::ST_IDLE;
      after_r   <= fan_regs_pkg::ST_IDLE;
      shift_r   <= 8'h00;
      cnt_r     <= `BIT_ZERO;
      got_r     <= 1'b0;
      sda_oe    <= 1'b0;
      ptr_r     <= 8'h00;
      wr_r      <= 1'b0;
      wr_data_r <= 8'h00;
    end else begin
      wr_r <= 1'b0;
      if (bus_start) begin
        state_r <= fan_regs_pkg::ST_ADDR;
        cnt_r   <= `BIT_ZERO;
        got_r   <= 1'b0;
        sda_oe  <= 1'b0;
      end else if (bus_stop) begin
        state_r <= fan_regs_pkg::ST_IDLE;
        sda_oe  <= 1'b0;
      end else begin
        case (state_r)
          fan_regs_pkg::ST_ADDR, fan_regs_pkg::ST_CMD, fan_regs_pkg::ST_WDATA: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_s_r};
              cnt_r   <= cnt_r + 3'h1;
              got_r   <= (cnt_r == `BYTE_LAST_BIT);
            end else if (scl_fall && got_r) begin
              got_r  <= 1'b0;
              sda_oe <= (state_r != fan_regs_pkg::ST_ADDR) || addr_hit;
              state_r <= fan_regs_pkg::ST_ACK;
              if (state_r == fan_regs_pkg::ST_ADDR) begin
                after_r <= shift_r[0] ? fan_regs_pkg::ST_RDATA : fan_regs_pkg::ST_CMD;
                if (!addr_hit) begin
                  state_r <= fan_regs_pkg::ST_IDLE;
                end
              end else if (state_r == fan_regs_pkg::ST_CMD) begin
                ptr_r   <= shift_r;
                after_r <= fan_regs_pkg::ST_WDATA;
              end else begin
                wr_r      <= 1'b1;
                wr_data_r <= shift_r;
                after_r   <= fan_regs_pkg::ST_WDATA;
              end
            end
          end
          fan_regs_pkg::ST_ACK: begin
            if (scl_fall) begin
              state_r <= after_r;
              if (after_r == fan_regs_pkg::ST_RDATA) begin
                shift_r <= rd_data;
                sda_oe  <= ~rd_data[7];
                cnt_r   <= 3'h1;
              end else begin
                sda_oe <= 1'b0;
                cnt_r  <= `BIT_ZERO;
              end
            end
          end
          fan_regs_pkg::ST_RDATA: begin
            if (scl_fall) begin
              if (cnt_r == `BIT_ZERO) begin
                sda_oe  <= 1'b0;
                state_r <= fan_regs_pkg::ST_RACK;
              end else begin
                sda_oe  <= ~shift_r[6];
                shift_r <= {shift_r[6:0], 1'b0};
                cnt_r   <= cnt_r + 3'h1;
              end
            end
          end
          fan_regs_pkg::ST_RACK: begin
            if (scl_rise) begin
              if (sda_s_r) begin
                state_r <= fan_regs_pkg::ST_IDLE;
              end else begin
                ptr_r   <= ptr_r + 8'h01;
                state_r <= fan_regs_pkg::ST_ACK;
                after_r <= fan_regs_pkg::ST_RDATA;
              end
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : fan_fan_pulse_count_and_diode_trim_regs

`default_nettype wire

// ---- verilog/fan_regs_defs.svh ----
// Register offsets, reset values, field positions and timing counts of the fan register bank.
`ifndef FAN_REGS_DEFS_SVH
`define FAN_REGS_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_ALERT_MASK       8'h16
`define OFS_IDEALITY_TRIM    8'h17
`define OFS_GAIN_COMP        8'h18
`define OFS_FAN_COUNT_LOW    8'h46
`define OFS_FAN_COUNT_HIGH   8'h47
`define OFS_FAN_LIMIT_LOW    8'h48
`define OFS_FAN_LIMIT_HIGH   8'h49

// ----------------------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------------------
`define RST_ALERT_MASK       8'ha4
`define RST_IDEALITY_TRIM    6'h12
`define RST_GAIN_COMP        4'h8
`define RST_BYTE_ONES        8'hff
`define RST_COUNT_ONES       16'hffff
`define BIT_CRIT_MASK        1
`define BIT_FAN_MASK         0
`define BIT_COMP_AUTO        3
`define COMP_OFF_CODE        3'h7
`define LIMIT_ACTION_NONE    2'h0
`define BYTE_LAST_BIT        3'h7
`define BIT_ZERO             3'h0

// ----------------------------------------------------------------------------
// Timing: one count reference tick is 1/90 kHz, so RPM = 5,400,000 / count.
// ----------------------------------------------------------------------------
`define CLK_HZ               100000000
`define TICK_HZ              90000
`define TICK_CYCLES          (`CLK_HZ / `TICK_HZ)

`endif

// ---- verilog/fan_regs_pkg.sv ----
// Types shared by the fan register bank.
package fan_regs_pkg;

  // --------------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic crit_temp_limit;
    logic fan_slow;
  } status_type;

  typedef struct packed {
    logic       auto_mode;
    logic [2:0] setting;
  } comp_type;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK
  } smb_state_type;

endpackage : fan_regs_pkg
